// ### hdl/ums_pkg.sv
// constants for the modem status, feature select and baud config block
// assumes an 8-bit register port with byte offsets as listed here
package ums_pkg;

    // register port, divisor, oversample and counter widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int DIV_W = 16;
    localparam int OVS_W = 4;
    localparam int CNT_W = 5;

    // register offsets
    localparam logic [7:0] OFS_DIV_LO = 8'h00;
    localparam logic [7:0] OFS_DIV_HI = 8'h01;
    localparam logic [7:0] OFS_OVS = 8'h02;
    localparam logic [7:0] OFS_LINE_FMT = 8'h03;
    localparam logic [7:0] OFS_MODEM_CTL = 8'h04;
    localparam logic [7:0] OFS_PEER_STAT = 8'h06;
    localparam logic [7:0] OFS_FEATURE = 8'h07;
    localparam logic [7:0] OFS_RX_COUNT = 8'h15;
    localparam logic [7:0] OFS_TX_OVS = 8'h16;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // line_format_reg field
    localparam int LF_DIV_ACCESS = 7;

    // modem control fields
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_OUT_A = 2;
    localparam int MC_OUT_B = 3;
    localparam int MC_LOOP = 4;
    localparam logic [7:0] MODEM_CTL_WMASK = 8'h1F;

    // peer_line_status fields
    localparam int PS_D_CTS = 0;
    localparam int PS_D_DSR = 1;
    localparam int PS_RI_RISE = 2;
    localparam int PS_D_DCD = 3;
    localparam int PS_CTS = 4;
    localparam int PS_DSR = 5;
    localparam int PS_RI = 6;
    localparam int PS_DCD = 7;

    // feature_select fields; bits 2 and 3 read as zero
    localparam int FS_FORCE_TX = 0;
    localparam int FS_AUTO_DSR = 1;
    localparam int FS_EXT_MODE = 5;
    localparam int FS_RX_SEL = 6;
    localparam int FS_TX_SEL = 7;
    localparam logic [7:0] FEATURE_WMASK = 8'hF3;

    // oversample_select field
    localparam logic [3:0] OVS_MAX_CODE = 4'hC;
    localparam logic [4:0] OVS_BASE = 5'h10;
    localparam logic [4:0] OVS_MIN = 5'h04;

endpackage

// ### hdl/ums_baud_gen.sv
// baud generator: reference clock / divisor gives the sample tick,
// sample tick / oversample count gives the bit tick
// assumes divisor and code are stable register outputs
`timescale 1ns/1ps
module ums_baud_gen #(
    parameter int DIV_W = ums_pkg::DIV_W,
    parameter int OVS_W = ums_pkg::OVS_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic [DIV_W-1:0] divisor,
    input wire logic [OVS_W-1:0] ovs_code,
    // ticks
    output logic sample_tick,
    output logic bit_tick
);

    // refuse widths the counters cannot serve, at elaboration
    if (DIV_W < 2 || OVS_W != ums_pkg::OVS_W)
    begin
        $error("ums_baud_gen: unsupported width");
    end

    logic [DIV_W-1:0] div_cnt_q, div_cnt_d;
    logic [ums_pkg::CNT_W-1:0] ovs_cnt_q, ovs_cnt_d;
    logic [ums_pkg::CNT_W-1:0] ovs_len;
    logic sample_tick_d, bit_tick_d;

    // reserved codes clamp to the shortest count so the bit tick never stops
    always_comb
    begin
        if (ovs_code > ums_pkg::OVS_MAX_CODE)
            ovs_len = ums_pkg::OVS_MIN;
        else
            ovs_len = ums_pkg::OVS_BASE - {1'b0, ovs_code};
    end

    // divide by divisor, then by the oversample count
    always_comb
    begin
        div_cnt_d = div_cnt_q;
        ovs_cnt_d = ovs_cnt_q;
        sample_tick_d = 1'b0;
        bit_tick_d = 1'b0;
        if (divisor == '0)
        begin
            // zero divisor: generator parked, no ticks at all
            div_cnt_d = '0;
            ovs_cnt_d = '0;
        end
        else if (div_cnt_q >= divisor - 1'b1)
        begin
            div_cnt_d = '0;
            sample_tick_d = 1'b1;
            if (ovs_cnt_q >= ovs_len - 1'b1)
            begin
                ovs_cnt_d = '0;
                bit_tick_d = 1'b1;
            end
            else
                ovs_cnt_d = ovs_cnt_q + 1'b1;
        end
        else
            div_cnt_d = div_cnt_q + 1'b1;
    end

    // counter and tick registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt_q <= '0;
            ovs_cnt_q <= '0;
            sample_tick <= 1'b0;
            bit_tick <= 1'b0;
        end
        else
        begin
            div_cnt_q <= div_cnt_d;
            ovs_cnt_q <= ovs_cnt_d;
            sample_tick <= sample_tick_d;
            bit_tick <= bit_tick_d;
        end
    end

endmodule

// ### hdl/ums_top.sv
// modem status capture, feature select, divisor latches and oversample
// select for one uart channel, behind an 8-bit strobe register port
// assumes modem inputs and counter inputs are synchronous to CLK
//
// Functional notes
// - status bit 0 sets on any change of the clear-to-send input
// - status bit 1 sets on any change of the data-set-ready input
// - status bit 2 sets only on a rising edge of ring indicator
// - status bit 3 sets on any change of the carrier detect input
// - reading the status register clears its four change bits
// - status bits 4 and 5 show clear-to-send and set-ready levels
// - status bits 6 and 7 show ring and carrier levels
// - feature bit 0 forces the transmitter to send regardless of flow
// - feature bit 1 enables set-ready / terminal-ready automatic flow control
// - feature bit 5 selects extended compatibility mode
// - feature bit 6 picks line-status counter or receive fill at 15h
// - feature bit 7 picks transmit fill or oversample register at 16h
// - with divisor access set, offset 00h is the divisor low byte
// - with divisor access set, offset 01h is the divisor high byte
// - with divisor access set, offset 02h is oversample, top nibble zero
// - oversample count is sixteen minus code, four at code 1100b and above
// - loopback routes general output a to ring, b to carrier
`timescale 1ns/1ps
module ums_top (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // register port
    input wire logic [ums_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [ums_pkg::DATA_W-1:0] REG_WDATA,
    output logic [ums_pkg::DATA_W-1:0] REG_RDATA,
    // modem lines from the peer
    input wire logic CTS,
    input wire logic DSR,
    input wire logic RI,
    input wire logic DCD,
    // modem lines to the peer
    output logic RTS,
    output logic DTR,
    // counters and the near-full flag from the data path
    input wire logic [ums_pkg::DATA_W-1:0] RX_FILL_COUNT,
    input wire logic [ums_pkg::DATA_W-1:0] LINE_STATE_COUNT,
    input wire logic [ums_pkg::DATA_W-1:0] TX_FILL_COUNT,
    input wire logic RX_NEAR_FULL,
    // controls to the data path
    output logic FORCE_TX,
    output logic TX_PERMIT,
    output logic EXT_MODE,
    output logic LOOPBACK,
    output logic DIV_ACCESS,
    // baud ticks
    output logic SAMPLE_TICK,
    output logic BIT_TICK
);

    // configuration registers
    logic [7:0] div_lo_q, div_lo_d;
    logic [7:0] div_hi_q, div_hi_d;
    logic [3:0] ovs_q, ovs_d;
    logic [7:0] line_fmt_q, line_fmt_d;
    logic [7:0] modem_ctl_q, modem_ctl_d;
    logic [7:0] feature_q, feature_d;

    // status capture state
    logic [3:0] lvl_q, lvl_d;
    logic [3:0] delta_q, delta_d;
    logic primed_q, primed_d;
    logic [7:0] rdata_q, rdata_d;

    // decoded accesses and effective line levels
    logic div_sel;
    logic loop_on;
    logic cts_eff, dsr_eff, ri_eff, dcd_eff;
    logic [3:0] lvl_now;
    logic [3:0] change;
    logic stat_rd;
    logic [7:0] stat_word;
    logic [7:0] rd_mux;

    // divisor access and loopback come straight from their registers
    assign div_sel = line_fmt_q[ums_pkg::LF_DIV_ACCESS];
    assign loop_on = modem_ctl_q[ums_pkg::MC_LOOP];

    // in loopback the peer lines are replaced by our own outputs
    always_comb
    begin
        if (loop_on)
        begin
            cts_eff = modem_ctl_q[ums_pkg::MC_RTS];
            dsr_eff = modem_ctl_q[ums_pkg::MC_DTR];
            ri_eff = modem_ctl_q[ums_pkg::MC_OUT_A];
            dcd_eff = modem_ctl_q[ums_pkg::MC_OUT_B];
        end
        else
        begin
            cts_eff = CTS;
            dsr_eff = DSR;
            ri_eff = RI;
            dcd_eff = DCD;
        end
    end

    // current levels, ordered as the low nibble of the change bits
    assign lvl_now = {dcd_eff, ri_eff, dsr_eff, cts_eff};

    // change detection; ring counts only its 0 to 1 edge
    always_comb
    begin
        change = '0;
        if (primed_q)
        begin
            change[ums_pkg::PS_D_CTS] = lvl_now[0] ^ lvl_q[0];
            change[ums_pkg::PS_D_DSR] = lvl_now[1] ^ lvl_q[1];
            change[ums_pkg::PS_RI_RISE] = lvl_now[2] & ~lvl_q[2];
            change[ums_pkg::PS_D_DCD] = lvl_now[3] ^ lvl_q[3];
        end
    end

    // a read of the status register is a clearing read
    assign stat_rd = REG_RD && (REG_ADDR == ums_pkg::OFS_PEER_STAT);

    // sticky change bits: set beats the read-clear in the same cycle
    always_comb
    begin
        lvl_d = lvl_now;
        primed_d = 1'b1;
        if (stat_rd)
            delta_d = change;
        else
            delta_d = delta_q | change;
    end

    // level history and change bits
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            lvl_q <= ums_pkg::RST_NIBBLE;
            delta_q <= ums_pkg::RST_NIBBLE;
            primed_q <= 1'b0;
        end
        else
        begin
            lvl_q <= lvl_d;
            delta_q <= delta_d;
            primed_q <= primed_d;
        end
    end

    // status word: registered levels above, change bits below
    always_comb
    begin
        stat_word = '0;
        stat_word[ums_pkg::PS_D_CTS] = delta_q[ums_pkg::PS_D_CTS];
        stat_word[ums_pkg::PS_D_DSR] = delta_q[ums_pkg::PS_D_DSR];
        stat_word[ums_pkg::PS_RI_RISE] = delta_q[ums_pkg::PS_RI_RISE];
        stat_word[ums_pkg::PS_D_DCD] = delta_q[ums_pkg::PS_D_DCD];
        stat_word[ums_pkg::PS_CTS] = lvl_q[0];
        stat_word[ums_pkg::PS_DSR] = lvl_q[1];
        stat_word[ums_pkg::PS_RI] = lvl_q[2];
        stat_word[ums_pkg::PS_DCD] = lvl_q[3];
    end

    // register writes; offsets 00h-02h belong to other blocks unless
    // divisor access is set, so writes there are ignored here
    always_comb
    begin
        div_lo_d = div_lo_q;
        div_hi_d = div_hi_q;
        ovs_d = ovs_q;
        line_fmt_d = line_fmt_q;
        modem_ctl_d = modem_ctl_q;
        feature_d = feature_q;
        if (REG_WR)
        begin
            unique case (REG_ADDR)
                ums_pkg::OFS_DIV_LO:
                begin
                    if (div_sel)
                        div_lo_d = REG_WDATA;
                end
                ums_pkg::OFS_DIV_HI:
                begin
                    if (div_sel)
                        div_hi_d = REG_WDATA;
                end
                ums_pkg::OFS_OVS:
                begin
                    if (div_sel)
                        ovs_d = REG_WDATA[ums_pkg::OVS_W-1:0];
                end
                ums_pkg::OFS_LINE_FMT:
                    line_fmt_d = REG_WDATA;
                ums_pkg::OFS_MODEM_CTL:
                    modem_ctl_d = REG_WDATA & ums_pkg::MODEM_CTL_WMASK;
                ums_pkg::OFS_FEATURE:
                    feature_d = REG_WDATA & ums_pkg::FEATURE_WMASK;
                ums_pkg::OFS_TX_OVS:
                begin
                    // fill count view is read only
                    if (!feature_q[ums_pkg::FS_TX_SEL])
                        ovs_d = REG_WDATA[ums_pkg::OVS_W-1:0];
                end
                default:
                    ;
            endcase
        end
    end

    // configuration register bank
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            div_lo_q <= ums_pkg::RST_BYTE;
            div_hi_q <= ums_pkg::RST_BYTE;
            ovs_q <= ums_pkg::RST_NIBBLE;
            line_fmt_q <= ums_pkg::RST_BYTE;
            modem_ctl_q <= ums_pkg::RST_BYTE;
            feature_q <= ums_pkg::RST_BYTE;
        end
        else
        begin
            div_lo_q <= div_lo_d;
            div_hi_q <= div_hi_d;
            ovs_q <= ovs_d;
            line_fmt_q <= line_fmt_d;
            modem_ctl_q <= modem_ctl_d;
            feature_q <= feature_d;
        end
    end

    // read mux; unmapped offsets and hidden views read as zero
    always_comb
    begin
        rd_mux = '0;
        unique case (REG_ADDR)
            ums_pkg::OFS_DIV_LO:
            begin
                if (div_sel)
                    rd_mux = div_lo_q;
            end
            ums_pkg::OFS_DIV_HI:
            begin
                if (div_sel)
                    rd_mux = div_hi_q;
            end
            ums_pkg::OFS_OVS:
            begin
                if (div_sel)
                    rd_mux = {4'h0, ovs_q};
            end
            ums_pkg::OFS_LINE_FMT:
                rd_mux = line_fmt_q;
            ums_pkg::OFS_MODEM_CTL:
                rd_mux = modem_ctl_q;
            ums_pkg::OFS_PEER_STAT:
                rd_mux = stat_word;
            ums_pkg::OFS_FEATURE:
                rd_mux = feature_q;
            ums_pkg::OFS_RX_COUNT:
            begin
                if (feature_q[ums_pkg::FS_RX_SEL])
                    rd_mux = LINE_STATE_COUNT;
                else
                    rd_mux = RX_FILL_COUNT;
            end
            ums_pkg::OFS_TX_OVS:
            begin
                if (feature_q[ums_pkg::FS_TX_SEL])
                    rd_mux = TX_FILL_COUNT;
                else
                    rd_mux = {4'h0, ovs_q};
            end
            default:
                rd_mux = '0;
        endcase
    end

    // read data is captured on the strobe and held until the next read
    always_comb
    begin
        rdata_d = rdata_q;
        if (REG_RD)
            rdata_d = rd_mux;
    end

    // read data register
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            rdata_q <= ums_pkg::RST_BYTE;
        else
            rdata_q <= rdata_d;
    end

    assign REG_RDATA = rdata_q;

    // feature, loopback and divisor access controls to the data path
    assign FORCE_TX = feature_q[ums_pkg::FS_FORCE_TX];
    assign EXT_MODE = feature_q[ums_pkg::FS_EXT_MODE];
    assign LOOPBACK = loop_on;
    assign DIV_ACCESS = div_sel;

    // forcing overrides the set-ready gate; without auto control the
    // transmitter is never held here
    assign TX_PERMIT = feature_q[ums_pkg::FS_FORCE_TX]
        | ~feature_q[ums_pkg::FS_AUTO_DSR]
        | lvl_q[1];

    // outputs to the peer are held low in loopback so the line is quiet
    always_comb
    begin
        RTS = 1'b0;
        DTR = 1'b0;
        if (!loop_on)
        begin
            RTS = modem_ctl_q[ums_pkg::MC_RTS];
            if (feature_q[ums_pkg::FS_AUTO_DSR])
                DTR = ~RX_NEAR_FULL;
            else
                DTR = modem_ctl_q[ums_pkg::MC_DTR];
        end
    end

    // baud generator on the divisor latches and oversample field
    ums_baud_gen #(
        .DIV_W(ums_pkg::DIV_W),
        .OVS_W(ums_pkg::OVS_W)
    ) u_baud (
        .clk(CLK),
        .rst(SYS_RST),
        .divisor({div_hi_q, div_lo_q}),
        .ovs_code(ovs_q),
        .sample_tick(SAMPLE_TICK),
        .bit_tick(BIT_TICK)
    );

endmodule

// ### tb/ums_monitor.sv
// checker for the status, feature and divisor port of ums_top
// assumes it is bound to ums_top and sees its ports only
`timescale 1ns/1ps
module ums_monitor (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // register port
    input wire logic [ums_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [ums_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic [ums_pkg::DATA_W-1:0] REG_RDATA,
    // modem lines
    input wire logic CTS,
    input wire logic DSR,
    input wire logic RI,
    input wire logic DCD,
    // controls and ticks
    input wire logic FORCE_TX,
    input wire logic EXT_MODE,
    input wire logic LOOPBACK,
    input wire logic DIV_ACCESS,
    input wire logic SAMPLE_TICK,
    input wire logic BIT_TICK
);
    logic [1:0] up_q;
    logic [1:0] up_d;
    logic [2:0] lb_q;
    logic [2:0] lb_d;
    logic [3:0] pins;
    logic stat_rd;
    logic quiet;
    // edges since reset and recent loopback; loopback hides the pins
    always_comb
    begin
        up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
        lb_d = {lb_q[1:0], LOOPBACK};
    end
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            up_q <= 2'h0;
            lb_q <= 3'h0;
        end
        else
        begin
            up_q <= up_d;
            lb_q <= lb_d;
        end
    end
    assign pins = {DCD, RI, DSR, CTS};
    assign stat_rd = REG_RD && REG_ADDR == ums_pkg::OFS_PEER_STAT;
    assign quiet = up_q == 2'h3 && lb_q == 3'h0 && !LOOPBACK;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // two status reads on consecutive edges
    sequence s_first_rd;
        stat_rd && quiet;
    endsequence
    sequence s_back_rd;
        s_first_rd ##1 (stat_rd && !LOOPBACK);
    endsequence
    // shortest bit period is four sample ticks of one cycle each
    sequence s_bit_gap;
        (!BIT_TICK) [*3];
    endsequence
    a_level_bits: assert property (
        stat_rd && quiet |=> REG_RDATA[7:4] == $past(pins, 2))
        else $error("status levels differ from the pins");
    a_delta_any: assert property (
        s_back_rd |=> REG_RDATA[0] == ($past(CTS, 2) != $past(CTS, 3))
        && REG_RDATA[1] == ($past(DSR, 2) != $past(DSR, 3))
        && REG_RDATA[3] == ($past(DCD, 2) != $past(DCD, 3)))
        else $error("change bits wrong after a status read");
    a_ri_rise_only: assert property (
        s_back_rd |=> REG_RDATA[2] == ($past(RI, 2) && !$past(RI, 3)))
        else $error("ring edge bit wrong after a status read");
    a_div_access: assert property (
        REG_WR && REG_ADDR == ums_pkg::OFS_LINE_FMT
        |=> DIV_ACCESS == $past(REG_WDATA[7]))
        else $error("divisor access does not follow the write");
    a_feature_out: assert property (
        REG_WR && REG_ADDR == ums_pkg::OFS_FEATURE |=> FORCE_TX ==
        $past(REG_WDATA[0]) && EXT_MODE == $past(REG_WDATA[5]))
        else $error("feature outputs do not follow the write");
    a_div_hidden: assert property (
        REG_RD && REG_ADDR <= ums_pkg::OFS_OVS && !DIV_ACCESS
        |=> REG_RDATA == 8'h00)
        else $error("divisor space readable without access");
    a_ovs_upper: assert property (
        REG_RD && REG_ADDR == ums_pkg::OFS_OVS |=> REG_RDATA[7:4] == 4'h0)
        else $error("oversample upper nibble not zero");
    a_tick_pair: assert property (
        BIT_TICK |-> SAMPLE_TICK ##1 s_bit_gap)
        else $error("bit tick without sample tick or too soon");
endmodule
bind ums_top ums_monitor i_ums_monitor (.CLK, .SYS_RST, .REG_ADDR,
    .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .CTS, .DSR, .RI, .DCD,
    .FORCE_TX, .EXT_MODE, .LOOPBACK, .DIV_ACCESS, .SAMPLE_TICK,
    .BIT_TICK);

// ### tb/ums_peer_model.sv
// peer modem: drives the four status lines toward the uart
// assumes the bench asks for levels and a reaction delay
`timescale 1ns/1ps
module ums_peer_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wanted levels {dcd, ri, dsr, cts} and delay in cycles
    input wire logic [3:0] want,
    input wire logic [3:0] lag,
    // lines toward the uart
    output logic [3:0] lines
);
    logic [3:0] want_q;
    logic [3:0] lag_q;
    int wait_n;
    // requests taken on the rising edge so the falling edge never races
    always @(posedge clk)
    begin
        want_q <= want;
        lag_q <= lag;
    end
    // a slow peer holds the old levels for lag cycles
    always @(negedge clk or posedge rst)
        if (rst)
            lines <= 4'h0;
        else if (want_q == lines)
            wait_n <= 0;
        else if (wait_n < lag_q)
            wait_n <= wait_n + 1;
        else
            lines <= want_q;
endmodule

// ### tb/tb_ums_top.sv
// bench for ums_top: strobe register tasks, peer model on the lines
// assumes the checker is bound to the design
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_ums_top;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [7:0] REG_ADDR = 8'h00;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [7:0] REG_WDATA = 8'h00;
    logic [7:0] REG_RDATA;
    logic [3:0] pins;
    logic [3:0] want = 4'h0;
    logic [3:0] lag = 4'h0;
    logic near_full = 1'b0;
    logic RTS, DTR, FORCE_TX, TX_PERMIT, EXT_MODE, LOOPBACK, DIV_ACCESS;
    logic SAMPLE_TICK, BIT_TICK;
    logic [3:0] codes [4] = '{4'h0, 4'h5, 4'hC, 4'hF};
    int ovs_n [4] = '{16, 11, 4, 4};
    int n_fail = 0;
    int cmp_count = 0;
    int n;
    ums_top i_ums_top (.CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA), .CTS(pins[0]), .DSR(pins[1]), .RI(pins[2]),
        .DCD(pins[3]), .RTS(RTS), .DTR(DTR), .RX_FILL_COUNT(8'h5A),
        .LINE_STATE_COUNT(8'h3C), .TX_FILL_COUNT(8'hC3),
        .RX_NEAR_FULL(near_full), .FORCE_TX(FORCE_TX),
        .TX_PERMIT(TX_PERMIT), .EXT_MODE(EXT_MODE), .LOOPBACK(LOOPBACK),
        .DIV_ACCESS(DIV_ACCESS), .SAMPLE_TICK(SAMPLE_TICK),
        .BIT_TICK(BIT_TICK));
    ums_peer_model i_ums_peer_model (.clk(CLK), .rst(SYS_RST),
        .want(want), .lag(lag), .lines(pins));
    // 20 MHz clock
    initial
        forever #25 CLK = ~CLK;
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(negedge CLK);
        REG_WR = 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge CLK);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge CLK);
        REG_RD = 1'b0;
        `CHK(REG_RDATA, e)
    endtask
    // two reads on consecutive edges
    task rd2(input logic [7:0] a, input logic [7:0] e1, e2);
        @(negedge CLK);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge CLK);
        `CHK(REG_RDATA, e1)
        @(negedge CLK);
        REG_RD = 1'b0;
        `CHK(REG_RDATA, e2)
    endtask
    // cycles between bit ticks, bounded so a dead generator ends it
    task per(output int p);
        for (int k = 0; k < 2000 && BIT_TICK !== 1'b1; k++)
            @(negedge CLK);
        p = 0;
        do
        begin
            @(negedge CLK);
            p++;
        end
        while (BIT_TICK !== 1'b1 && p < 2000);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog well past the few thousand cycles of the run
    initial
    begin
        #1000000;
        n_fail++;
        summarize;
    end
    initial
    begin
        repeat (4) @(posedge CLK);
        @(negedge CLK) SYS_RST = 1'b0;
        rdc(8'h06, 8'h00);
        rdc(8'h07, 8'h00);
        `CHK(TX_PERMIT, 1'b1)
        wr(8'h00, 8'h55);
        rdc(8'h00, 8'h00);
        wr(8'h03, 8'h80);
        rdc(8'h00, 8'h00);
        rdc(8'h01, 8'h00);
        rdc(8'h02, 8'h00);
        rdc(8'h30, 8'h00);
        wr(8'h02, 8'hFF);
        rdc(8'h02, 8'h0F);
        wr(8'h00, 8'h03);
        rdc(8'h00, 8'h03);
        wr(8'h01, 8'hA5);
        rdc(8'h01, 8'hA5);
        wr(8'h01, 8'h00);
        foreach (codes[i])
        begin
            wr(8'h02, codes[i]);
            per(n);
            per(n);
            `CHK(n, 3 * ovs_n[i])
        end
        wr(8'h01, 8'h01);
        wr(8'h00, 8'h00);
        per(n);
        per(n);
        `CHK(n, 1024)
        wr(8'h01, 8'h00);
        repeat (4) @(negedge CLK);
        n = 0;
        repeat (40) @(negedge CLK) if (SAMPLE_TICK !== 1'b0) n++;
        `CHK(n, 0)
        for (int i = 0; i < 4; i++)
        begin
            want[i] = 1'b1;
            repeat (3) @(negedge CLK);
            rdc(8'h06, {want, 4'h0} | (8'h01 << i));
        end
        rd2(8'h06, 8'hF0, 8'hF0);
        want = 4'h0;
        lag = 4'h5;
        repeat (9) @(negedge CLK);
        rdc(8'h06, 8'h0B);
        lag = 4'h0;
        want = 4'h1;
        rd2(8'h06, 8'h00, 8'h11);
        want = 4'h0;
        wr(8'h07, 8'hFF);
        rdc(8'h07, 8'hF3);
        `CHK(EXT_MODE, 1'b1)
        rdc(8'h15, 8'h3C);
        rdc(8'h16, 8'hC3);
        wr(8'h16, 8'h05);
        rdc(8'h02, 8'h0F);
        wr(8'h02, 8'h09);
        wr(8'h07, 8'h02);
        rdc(8'h15, 8'h5A);
        rdc(8'h16, 8'h09);
        wr(8'h16, 8'h07);
        rdc(8'h02, 8'h07);
        `CHK(TX_PERMIT, 1'b0)
        wr(8'h07, 8'h03);
        `CHK(TX_PERMIT, 1'b1)
        wr(8'h07, 8'h02);
        want = 4'h2;
        near_full = 1'b1;
        repeat (3) @(negedge CLK);
        `CHK(TX_PERMIT, 1'b1)
        `CHK(DTR, 1'b0)
        near_full = 1'b0;
        @(negedge CLK);
        `CHK(DTR, 1'b1)
        want = 4'h0;
        repeat (3) @(negedge CLK);
        rdc(8'h06, 8'h03);
        wr(8'h04, 8'h02);
        `CHK(RTS, 1'b1)
        wr(8'h04, 8'h1E);
        `CHK(LOOPBACK, 1'b1)
        `CHK({RTS, DTR}, 2'b00)
        repeat (2) @(negedge CLK);
        rdc(8'h06, 8'hDD);
        summarize;
    end
endmodule
